// ### logic/hscmc_defs.vh
// constants for the high-speed counter mode and compare control block
`ifndef HSCMC_DEFS_VH
`define HSCMC_DEFS_VH

// register byte offsets on the axi4-lite bus
`define HSCMC_REG_CTRL 8'h00
`define HSCMC_REG_DIR_SEL 8'h04
`define HSCMC_REG_DIR_MON 8'h08
`define HSCMC_REG_OP_STATUS 8'h0c
`define HSCMC_REG_CNT_EN 8'h10
`define HSCMC_REG_CNT_SEL 8'h14
`define HSCMC_REG_CNT_VAL 8'h18
`define HSCMC_REG_CMP_SEL 8'h1c
`define HSCMC_REG_CMP_CFG 8'h20
`define HSCMC_REG_CMP_VAL 8'h24
`define HSCMC_REG_OUT_STATE 8'h28
`define HSCMC_REG_IRQ_STATUS 8'h2c
`define HSCMC_REG_IRQ_MASK 8'h30
`define HSCMC_REG_LAST 8'h30

// control register bit positions
`define HSCMC_CTRL_MASTER 0
`define HSCMC_CTRL_INVERT 1
`define HSCMC_CTRL_ALT_A 2
`define HSCMC_CTRL_ALT_B 3
`define HSCMC_CTRL_ALT_C 4
`define HSCMC_CTRL_EDGE_LOWER 5
`define HSCMC_CTRL_EDGE_UPPER 6
`define HSCMC_CTRL_RUN 7

// reset values
`define HSCMC_RST_CTRL 8'h00
`define HSCMC_RST_DIR_SEL 11'h000
`define HSCMC_RST_CNT_EN 21'h000000
`define HSCMC_RST_IRQ_MASK 2'h0

// counter bank layout: 11 single-input, 5 dual-input, 5 two-phase
`define HSCMC_NUM_CNT 21
`define HSCMC_NUM_SINGLE 11
`define HSCMC_FIRST_TWO_PHASE 16
`define HSCMC_NUM_CMP 32
`define HSCMC_IDX_ALT_A 9
`define HSCMC_IDX_ALT_B 10
`define HSCMC_IDX_DUAL_UPPER 13
`define HSCMC_IDX_TWO_PHASE_UPPER 18
`define HSCMC_TERM_SIX 3'h6
`define HSCMC_TERM_SEVEN 3'h7
// counters that are hardware-implemented with no option active
`define HSCMC_HW_BASE 21'h05083f

// compare slot types and configuration fields
`define HSCMC_CMP_OFF 2'h0
`define HSCMC_CMP_SET 2'h1
`define HSCMC_CMP_RESET 2'h2
`define HSCMC_CMP_ZONE 2'h3

// interrupt status bits
`define HSCMC_IRQ_CMP_HIT 0
`define HSCMC_IRQ_EXT_RESET 1

// axi response codes
`define HSCMC_RESP_OKAY 2'h0
`define HSCMC_RESP_SLVERR 2'h2

`endif

// ### logic/hscmc_axil.v
// axi4-lite slave front end that turns bus transfers into register strobes
`include "hscmc_defs.vh"
`default_nettype none

module hscmc_axil (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg wr_en,
  output reg [7:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  output reg [7:0] rd_addr,
  input wire [31:0] rd_data
);

  reg aw_held; // write address taken, waiting for data
  reg w_held; // write data taken, waiting for address
  reg rd_pend; // read address taken, data sampled next edge

  // aligned and inside the map, anything else answers slverr
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[1:0] == 2'h0) && (a <= `HSCMC_REG_LAST);
    end
  endfunction

  // write channel: address and data accepted in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HSCMC_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      wr_en <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      // both halves present: fire one write strobe if the address is good, and answer
      if (aw_held && w_held && !s_axi_bvalid) begin
        wr_en <= addr_ok(wr_addr);
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(wr_addr) ? `HSCMC_RESP_OKAY : `HSCMC_RESP_SLVERR;
      end
      // readiness returns only after the response is taken, one write at a time
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: address latched, data sampled one edge later
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `HSCMC_RESP_OKAY;
      rd_addr <= 8'h00;
      rd_pend <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_addr <= s_axi_araddr;
        rd_pend <= 1'b1;
      end
      if (rd_pend) begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= addr_ok(rd_addr) ? rd_data : 32'h00000000;
        s_axi_rresp <= addr_ok(rd_addr) ? `HSCMC_RESP_OKAY : `HSCMC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### logic/hscmc_top.v
// high-speed counter bank with mode switching, direction control and compare outputs
`include "hscmc_defs.vh"
`default_nettype none

module hscmc_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] input_terminal,
  output reg [7:0] compare_out,
  output reg irq
);

  wire wr_en; // one-cycle register write strobe
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [7:0] rd_addr;
  reg [31:0] rd_data; // read mux, sampled by the bus front end

  reg [7:0] ctrl; // mode bits and run flag
  reg [10:0] dir_sel; // direction select, one per single-input counter
  reg [9:0] dir_mon; // last direction of dual and two-phase counters
  reg [7:0] op_status; // software/hardware status per group
  reg [20:0] cnt_en; // counters the program has in use
  reg [4:0] cnt_sel;
  reg [31:0] cnt_snap; // value latched when cnt_sel is written
  reg [4:0] cmp_sel;
  reg [9:0] cmp_cfg_mem [0:31]; // type[1:0], counter[6:2], output[9:7]
  reg [31:0] cmp_val_mem [0:31];
  reg [31:0] count_mem [0:20]; // current values
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [7:0] in_q; // terminals this cycle
  reg [7:0] in_p; // terminals last cycle, for edge detection
  reg run_q; // run flag of the previous cycle

  // combinational results of the counting step
  reg [31:0] next_count [0:20];
  reg [20:0] up_v;
  reg [20:0] dn_v;
  reg [20:0] rst_v;
  reg [20:0] used_by_cmp;
  reg [7:0] next_compare_out;
  reg next_hit;
  reg [7:0] next_op;
  reg [13:0] tm;
  reg gate;
  reg edge4;
  reg [1:0] qstep;
  reg [1:0] ctype;
  reg [4:0] cidx;
  reg [20:0] hw_eff;
  integer i;
  integer s;
  integer k;
  integer m;

  wire master = ctrl[`HSCMC_CTRL_MASTER];
  wire inv_eff = master & ctrl[`HSCMC_CTRL_INVERT];
  wire alt_a = master & ctrl[`HSCMC_CTRL_ALT_A];
  wire alt_b = master & ctrl[`HSCMC_CTRL_ALT_B];
  wire alt_c = master & ctrl[`HSCMC_CTRL_ALT_C];
  wire run_edge = ctrl[`HSCMC_CTRL_RUN] & ~run_q;

  // terminal map per counter: {has_r, r, has_s, s, a/up, b/down}
  function [13:0] term_map;
    input [4:0] idx;
    begin
      case (idx)
        5'd0: term_map = {4'h0, 4'h0, 3'h0, 3'h0};
        5'd1: term_map = {4'h0, 4'h0, 3'h1, 3'h0};
        5'd2: term_map = {4'h0, 4'h0, 3'h2, 3'h0};
        5'd3: term_map = {4'h0, 4'h0, 3'h3, 3'h0};
        5'd4: term_map = {4'h0, 4'h0, 3'h4, 3'h0};
        5'd5: term_map = {4'h0, 4'h0, 3'h5, 3'h0};
        5'd6: term_map = {4'h9, 4'h0, 3'h0, 3'h0};
        5'd7: term_map = {4'hb, 4'h0, 3'h2, 3'h0};
        5'd8: term_map = {4'hd, 4'h0, 3'h4, 3'h0};
        5'd9: term_map = {4'h9, 4'he, 3'h0, 3'h0};
        5'd10: term_map = {4'hb, 4'hf, 3'h2, 3'h0};
        5'd11: term_map = {4'h0, 4'h0, 3'h0, 3'h1};
        5'd12: term_map = {4'ha, 4'h0, 3'h0, 3'h1};
        5'd13: term_map = {4'hd, 4'h0, 3'h3, 3'h4};
        5'd14: term_map = {4'ha, 4'he, 3'h0, 3'h1};
        5'd15: term_map = {4'hd, 4'hf, 3'h3, 3'h4};
        5'd16: term_map = {4'h0, 4'h0, 3'h0, 3'h1};
        5'd17: term_map = {4'ha, 4'h0, 3'h0, 3'h1};
        5'd18: term_map = {4'hd, 4'h0, 3'h3, 3'h4};
        5'd19: term_map = {4'ha, 4'he, 3'h0, 3'h1};
        5'd20: term_map = {4'hd, 4'hf, 3'h3, 3'h4};
        default: term_map = 14'h0000;
      endcase
    end
  endfunction

  // status group of a counter; the alternates report on groups six and seven
  function [2:0] grp_of;
    input [4:0] idx;
    input aa;
    input ab;
    begin
      case (idx)
        5'd1: grp_of = 3'h1;
        5'd2, 5'd7: grp_of = 3'h2;
        5'd3, 5'd13, 5'd15, 5'd18, 5'd20: grp_of = 3'h3;
        5'd4, 5'd8: grp_of = 3'h4;
        5'd5: grp_of = 3'h5;
        5'd9: grp_of = aa ? 3'h6 : 3'h0;
        5'd10: grp_of = ab ? 3'h7 : 3'h2;
        default: grp_of = 3'h0;
      endcase
    end
  endfunction

  // four-edge quadrature step from {a,b} old and new: 01 up, 10 down
  function [1:0] quad_step;
    input [1:0] prev;
    input [1:0] cur;
    begin
      case ({prev, cur})
        4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b01;
        4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b10;
        default: quad_step = 2'b00;
      endcase
    end
  endfunction

  // merge written bytes into an old register value
  function [31:0] apply_strb;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    begin
      apply_strb[7:0] = strb[0] ? nw[7:0] : old[7:0];
      apply_strb[15:8] = strb[1] ? nw[15:8] : old[15:8];
      apply_strb[23:16] = strb[2] ? nw[23:16] : old[23:16];
      apply_strb[31:24] = strb[3] ? nw[31:24] : old[31:24];
    end
  endfunction

  // byte-merged write values, cut to each register's own width where they land
  wire [31:0] merged_ctrl = apply_strb({24'h000000, ctrl}, wr_data, wr_strb);
  wire [31:0] merged_dir_sel = apply_strb({21'h000000, dir_sel}, wr_data, wr_strb);
  wire [31:0] merged_cnt_en = apply_strb({11'h000, cnt_en}, wr_data, wr_strb);
  wire [31:0] merged_cmp_cfg = apply_strb({22'h000000, cmp_cfg_mem[cmp_sel]}, wr_data, wr_strb);

  hscmc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // counting step for every counter, from the registered terminal edges
  always @* begin
    tm = 14'h0000;
    gate = 1'b0;
    edge4 = 1'b0;
    qstep = 2'b00;
    up_v = 21'h000000;
    dn_v = 21'h000000;
    rst_v = 21'h000000;
    for (i = 0; i < `HSCMC_NUM_CNT; i = i + 1) begin
      tm = term_map(i[4:0]);
      // alternate allocations drop reset and start inputs
      if (i == `HSCMC_IDX_ALT_A && alt_a) begin
        tm = {8'h00, `HSCMC_TERM_SIX, 3'h0};
      end
      if (i == `HSCMC_IDX_ALT_B && alt_b) begin
        tm = {8'h00, `HSCMC_TERM_SEVEN, 3'h0};
      end
      if ((i == `HSCMC_IDX_DUAL_UPPER || i == `HSCMC_IDX_TWO_PHASE_UPPER) && alt_c) begin
        tm[13] = 1'b0;
      end
      gate = ~tm[9] | in_q[tm[8:6]];
      // one polarity for every reset-capable counter at once
      rst_v[i] = tm[13] & (in_q[tm[12:10]] ^ inv_eff);
      if (i < `HSCMC_NUM_SINGLE) begin
        // rising count edge, direction from the select bit
        if (in_q[tm[5:3]] & ~in_p[tm[5:3]]) begin
          up_v[i] = ~dir_sel[i];
          dn_v[i] = dir_sel[i];
        end
      end else if (i < `HSCMC_FIRST_TWO_PHASE) begin
        // simultaneous up and down edges cancel
        up_v[i] = in_q[tm[5:3]] & ~in_p[tm[5:3]] & ~(in_q[tm[2:0]] & ~in_p[tm[2:0]]);
        dn_v[i] = in_q[tm[2:0]] & ~in_p[tm[2:0]] & ~(in_q[tm[5:3]] & ~in_p[tm[5:3]]);
      end else begin
        edge4 = (i == 18 || i == 20) ? ctrl[`HSCMC_CTRL_EDGE_UPPER] :
                ctrl[`HSCMC_CTRL_EDGE_LOWER];
        if (edge4) begin
          qstep = quad_step({in_p[tm[5:3]], in_p[tm[2:0]]},
                            {in_q[tm[5:3]], in_q[tm[2:0]]});
        end else begin
          // one edge per cycle: phase of b at the a rise gives the direction
          qstep = (in_q[tm[5:3]] & ~in_p[tm[5:3]]) ? {in_q[tm[2:0]], ~in_q[tm[2:0]]} : 2'b00;
        end
        up_v[i] = qstep[0];
        dn_v[i] = qstep[1];
      end
      up_v[i] = up_v[i] & gate & cnt_en[i] & ~rst_v[i];
      dn_v[i] = dn_v[i] & gate & cnt_en[i] & ~rst_v[i];
      // a counted edge moves the value by exactly one
      if (rst_v[i]) begin
        next_count[i] = 32'h00000000;
      end else if (up_v[i]) begin
        next_count[i] = count_mem[i] + 32'h00000001;
      end else if (dn_v[i]) begin
        next_count[i] = count_mem[i] - 32'h00000001;
      end else begin
        next_count[i] = count_mem[i];
      end
    end
  end

  // compare slots judged on the same step that changes the count
  always @* begin
    next_compare_out = compare_out;
    next_hit = 1'b0;
    used_by_cmp = 21'h000000;
    ctype = 2'b00;
    cidx = 5'h00;
    for (s = 0; s < `HSCMC_NUM_CMP; s = s + 1) begin
      ctype = cmp_cfg_mem[s][1:0];
      cidx = cmp_cfg_mem[s][6:2];
      if (ctype != `HSCMC_CMP_OFF && cidx < `HSCMC_NUM_CNT) begin
        used_by_cmp[cidx] = 1'b1;
        if (up_v[cidx] | dn_v[cidx]) begin
          case (ctype)
            `HSCMC_CMP_SET: begin
              if (next_count[cidx] == cmp_val_mem[s]) begin
                next_compare_out[cmp_cfg_mem[s][9:7]] = 1'b1;
                next_hit = 1'b1;
              end
            end
            `HSCMC_CMP_RESET: begin
              if (next_count[cidx] == cmp_val_mem[s]) begin
                next_compare_out[cmp_cfg_mem[s][9:7]] = 1'b0;
                next_hit = 1'b1;
              end
            end
            default: begin
              // zone: output on while the count is at or above the value
              next_compare_out[cmp_cfg_mem[s][9:7]] = (next_count[cidx] >= cmp_val_mem[s]);
            end
          endcase
        end
      end
    end
  end

  // software/hardware classification folded into the status groups
  always @* begin
    hw_eff = `HSCMC_HW_BASE;
    hw_eff[`HSCMC_IDX_ALT_A] = alt_a;
    hw_eff[`HSCMC_IDX_ALT_B] = alt_b;
    hw_eff[`HSCMC_IDX_DUAL_UPPER] = alt_c;
    hw_eff[`HSCMC_IDX_TWO_PHASE_UPPER] = ~inv_eff & ~alt_c;
    // a compare on a hardware counter moves it to software
    hw_eff = hw_eff & ~used_by_cmp;
    next_op = 8'h00;
    for (k = 0; k < `HSCMC_NUM_CNT; k = k + 1) begin
      if (cnt_en[k] & ~hw_eff[k]) begin
        next_op[grp_of(k[4:0], alt_a, alt_b)] = 1'b1;
      end
    end
  end

  // register read mux, no side effects on read
  always @* begin
    case (rd_addr)
      `HSCMC_REG_CTRL: rd_data = {24'h000000, ctrl};
      `HSCMC_REG_DIR_SEL: rd_data = {21'h000000, dir_sel};
      `HSCMC_REG_DIR_MON: rd_data = {22'h000000, dir_mon};
      `HSCMC_REG_OP_STATUS: rd_data = {24'h000000, op_status};
      `HSCMC_REG_CNT_EN: rd_data = {11'h000, cnt_en};
      `HSCMC_REG_CNT_SEL: rd_data = {27'h0000000, cnt_sel};
      `HSCMC_REG_CNT_VAL: rd_data = cnt_snap;
      `HSCMC_REG_CMP_SEL: rd_data = {27'h0000000, cmp_sel};
      `HSCMC_REG_CMP_CFG: rd_data = {22'h000000, cmp_cfg_mem[cmp_sel]};
      `HSCMC_REG_CMP_VAL: rd_data = cmp_val_mem[cmp_sel];
      `HSCMC_REG_OUT_STATE: rd_data = {24'h000000, compare_out};
      `HSCMC_REG_IRQ_STATUS: rd_data = {30'h00000000, irq_status};
      `HSCMC_REG_IRQ_MASK: rd_data = {30'h00000000, irq_mask};
      default: rd_data = 32'h00000000;
    endcase
  end

  // state update: counters, outputs, status and register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `HSCMC_RST_CTRL;
      dir_sel <= `HSCMC_RST_DIR_SEL;
      dir_mon <= 10'h000;
      op_status <= 8'h00;
      cnt_en <= `HSCMC_RST_CNT_EN;
      cnt_sel <= 5'h00;
      cnt_snap <= 32'h00000000;
      cmp_sel <= 5'h00;
      irq_status <= 2'h0;
      irq_mask <= `HSCMC_RST_IRQ_MASK;
      in_q <= 8'h00;
      in_p <= 8'h00;
      run_q <= 1'b0;
      compare_out <= 8'h00;
      irq <= 1'b0;
      for (m = 0; m < `HSCMC_NUM_CMP; m = m + 1) begin
        cmp_cfg_mem[m] <= 10'h000;
        cmp_val_mem[m] <= 32'h00000000;
      end
      for (m = 0; m < `HSCMC_NUM_CNT; m = m + 1) begin
        count_mem[m] <= 32'h00000000;
      end
    end else begin
      in_q <= input_terminal;
      in_p <= in_q;
      run_q <= ctrl[`HSCMC_CTRL_RUN];
      compare_out <= next_compare_out;
      for (m = 0; m < `HSCMC_NUM_CNT; m = m + 1) begin
        count_mem[m] <= next_count[m];
      end
      // direction monitor follows the last counted step
      for (m = `HSCMC_NUM_SINGLE; m < `HSCMC_NUM_CNT; m = m + 1) begin
        if (dn_v[m]) begin
          dir_mon[m - `HSCMC_NUM_SINGLE] <= 1'b1;
        end else if (up_v[m]) begin
          dir_mon[m - `HSCMC_NUM_SINGLE] <= 1'b0;
        end
      end
      // the stop-to-run change wipes the status for one cycle
      op_status <= run_edge ? 8'h00 : next_op;
      irq <= |(irq_status & irq_mask);
      // events set, a written one clears; a new event wins
      irq_status[`HSCMC_IRQ_CMP_HIT] <= next_hit | (irq_status[`HSCMC_IRQ_CMP_HIT] &
        ~(wr_en && wr_addr == `HSCMC_REG_IRQ_STATUS && wr_strb[0] &&
          wr_data[`HSCMC_IRQ_CMP_HIT]));
      irq_status[`HSCMC_IRQ_EXT_RESET] <= (|(rst_v & cnt_en)) |
        (irq_status[`HSCMC_IRQ_EXT_RESET] &
        ~(wr_en && wr_addr == `HSCMC_REG_IRQ_STATUS && wr_strb[0] &&
          wr_data[`HSCMC_IRQ_EXT_RESET]));
      if (wr_en) begin
        case (wr_addr)
          `HSCMC_REG_CTRL: ctrl <= merged_ctrl[7:0];
          `HSCMC_REG_DIR_SEL: dir_sel <= merged_dir_sel[10:0];
          `HSCMC_REG_CNT_EN: cnt_en <= merged_cnt_en[20:0];
          `HSCMC_REG_CNT_SEL: begin
            // selecting a counter also latches its value for a later read
            if (wr_strb[0]) begin
              cnt_sel <= wr_data[4:0];
              cnt_snap <= (wr_data[4:0] < `HSCMC_NUM_CNT) ? count_mem[wr_data[4:0]] :
                          32'h00000000;
            end
          end
          `HSCMC_REG_CMP_SEL: begin
            if (wr_strb[0]) begin
              cmp_sel <= wr_data[4:0];
            end
          end
          `HSCMC_REG_CMP_CFG: cmp_cfg_mem[cmp_sel] <= merged_cmp_cfg[9:0];
          `HSCMC_REG_CMP_VAL: cmp_val_mem[cmp_sel] <=
            apply_strb(cmp_val_mem[cmp_sel], wr_data, wr_strb);
          `HSCMC_REG_IRQ_MASK: begin
            if (wr_strb[0]) begin
              irq_mask <= wr_data[1:0];
            end
          end
          default: begin
            // read-only and unmapped offsets ignore writes
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### sim/hscmc_pulse_src.sv
// field pulse source that drives the counter input terminals
`default_nettype none
module hscmc_pulse_src (
  input wire logic aclk,
  input wire logic [7:0] hold,
  input wire logic [7:0] tick,
  output logic [7:0] term
);
  timeunit 1ns;
  timeprecision 1ps;
  // registered so terminals only move just after an edge, like a real sensor sampled by the unit
  always @(posedge aclk) begin
    term <= hold | tick;
  end
endmodule
`default_nettype wire

// ### sim/hscmc_asserts.sv
// bus and output checks for the counter block
`default_nettype none
module hscmc_asserts (
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, irq,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [7:0] s_axi_araddr, compare_out,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // handshakes taken at this edge
  wire logic aw = s_axi_awvalid && s_axi_awready;
  wire logic ar = s_axi_arvalid && s_axi_arready;
  a_aw_busy: assert property (aw |=> !s_axi_awready) else $error("awready high after take");
  a_ar_busy: assert property (ar |=> !s_axi_arready) else $error("arready high after take");
  a_b_bound: assert property (aw && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("no write answer");
  a_r_bound: assert property (ar |-> ##[1:3] s_axi_rvalid) else $error("no read answer");
  a_rd_slverr: assert property (ar && s_axi_araddr > 8'h30 |-> ##[1:3] s_axi_rresp == 2'h2)
    else $error("bad address not refused");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer not retired");
  a_out_reset: assert property ($rose(aresetn) |-> compare_out == 8'h0 && !irq)
    else $error("outputs not cleared by reset");
  c_hit: cover property ($rose(compare_out[2]));
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind hscmc_top hscmc_asserts chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .irq, .s_axi_bresp, .s_axi_rresp, .s_axi_araddr, .compare_out, .s_axi_rdata);
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the counter mode and compare block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
  logic s_axi_rready = 1, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, hold = 0, tick = 0, input_terminal, compare_out;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h10, 8'h30};
  integer seed = 32'h9c2b;
  int n, fail_count = 0, n_checks = 0;
  hscmc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .input_terminal, .compare_out, .irq);
  hscmc_pulse_src ps_u (.aclk, .hold, .tick, .term(input_terminal));
  always #2 aclk = ~aclk;
  // bready and rready stay high so back-to-back calls never toggle them in one step;
  // each request channel is dropped at the edge it is taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, v, r);
    chk(nm, e, v);
  endtask
  // latch a counter through the select register, then read the held copy
  task cv(input logic [4:0] i, input logic [31:0] e);
    wr(8'h14, {27'h0, i});
    rc(8'h18, e, "count");
  endtask
  // one-cycle pulses; four spare cycles cover the source register and input pipeline
  task pl(input int t, input int k);
    repeat (k) begin
      tick <= 8'h1 << t;
      @(posedge aclk);
      tick <= 8'h0;
      @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (ra[i]) rc(ra[i], 32'h0, "reset value");
    rd(8'h34, v, r);
    chk("bad address", 32'h2, {30'h0, r});
    n = 3 + {$random(seed)} % 6;
    wr(8'h00, 32'h80);
    wr(8'h10, 32'h1);
    pl(0, n);
    cv(0, n);
    wr(8'h04, 32'h1);
    pl(0, 2);
    cv(0, n - 2);
    // set-type slot on counter 0 driving output bit 2 at value n, the only slot in use
    wr(8'h04, 32'h0);
    wr(8'h1c, 32'h0);
    wr(8'h20, 32'h101);
    wr(8'h24, n);
    wr(8'h30, 32'h1);
    pl(0, 1);
    chk("early output", 32'h0, {24'h0, compare_out});
    pl(0, 1);
    chk("compare output", 32'h4, {24'h0, compare_out});
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h30, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    // reset-type slot: one step up, then back down onto n clears the output
    wr(8'h20, 32'h102);
    pl(0, 1);
    wr(8'h04, 32'h1);
    pl(0, 1);
    chk("reset output", 32'h0, {24'h0, compare_out});
    // zone slot: a step up to n + 1 sits at or above n, so the output rises
    wr(8'h20, 32'h103);
    wr(8'h04, 32'h0);
    pl(0, 1);
    chk("zone output", 32'h4, {24'h0, compare_out});
    rc(8'h2c, 32'h1, "sticky status");
    wr(8'h2c, 32'h1);
    rc(8'h2c, 32'h0, "status cleared");
    wr(8'h20, 32'h0);
    // alternate a moves counter 9 to terminal six
    wr(8'h00, 32'h85);
    wr(8'h10, 32'h240);
    pl(6, n);
    cv(9, n);
    rc(8'h0c, 32'h1, "op status");
    // inverted reset: terminal one low now holds counter 6 cleared
    wr(8'h00, 32'h87);
    wr(8'h10, 32'h40040);
    pl(0, 3);
    cv(6, 0);
    rc(8'h0c, 32'h9, "op status inverted");
    rc(8'h2c, 32'h2, "reset event");
    // dropping and raising the run bit wipes the status for the cycle the read samples
    wr(8'h00, 32'h07);
    wr(8'h00, 32'h87);
    rc(8'h0c, 32'h0, "op status at run");
    hold <= 8'h2;
    pl(0, 3);
    cv(6, 3);
    // two-phase counter 16 with phase b held high counts down
    wr(8'h00, 32'h80);
    wr(8'h10, 32'h10000);
    pl(0, 2);
    cv(16, 32'hfffffffe);
    rc(8'h08, 32'h20, "direction monitor");
    wr(8'h00, 32'ha0);
    pl(0, 2);
    cv(16, 32'hfffffffe);
    stop_test;
  end
endmodule
`default_nettype wire
